// *** sensor_spi_regs.svh ***
// constants of the sensor serial slave: frame layout, codes and rates
// assumes nothing; included by the package and by the slave module
`ifndef SENSOR_SPI_REGS_SVH
`define SENSOR_SPI_REGS_SVH

`define SPI_FRAME_BITS    32
`define SPI_COUNT_LIMIT   33
`define SPI_BIT_MSB       31
`define SPI_BIT_NEXT      30
`define SPI_DATA_HI       31
`define SPI_DATA_LO       16
`define SPI_MODE_HI       15
`define SPI_MODE_LO       13
`define SPI_FLAG_HI       15
`define SPI_FLAG_LO       14
`define SPI_SELECT_HI     11
`define SPI_SELECT_LO     8
`define SPI_X2_POS        7
`define SPI_BODY_HI       31
`define SPI_BODY_LO       4
`define SPI_CRC_HI        3
`define SPI_CRC_LO        0
`define SPI_MODE_DATA     3'h5
`define SPI_FLAG_OK       2'h2
`define SPI_FLAG_ALARM    2'h1
`define SPI_MODE_ECHO     2'h2
`define SPI_CRC_INIT      4'ha
// all-zero body with its check bits, so even the first answer is well formed
`define SPI_RESET_RESP    32'h0000000a
`define SPI_FIXED_SELECT  4'hf
`define SPI_FIXED_VALUE   16'haa55
`define SPI_CLOCK_HZ      20000000
`define SPI_SAMPLE_HZ     8000
`define SPI_RATE_BITS     12
`define SPI_FIFO_DEPTH    8

`endif

// *** sensor_spi_pkg.sv ***
// types shared by the sensor serial slave and its test bench
// assumes sensor_spi_regs.svh is on the include path
`include "sensor_spi_regs.svh"
`default_nettype none

package sensor_spi_pkg;

   typedef enum logic {LINK_IDLE, LINK_FRAME} link_state_t;

   typedef struct packed {
      logic [3:0]  index;
      logic [15:0] value;
   } sample_t;

   typedef struct packed {
      logic [2:0]                       cs_n_sync;
      logic [2:0]                       sclk_sync;
      logic [1:0]                       mosi_sync;
      logic [1:0]                       hw_rst_sync;
      link_state_t                      link;
      logic [5:0]                       bit_count;
      logic [31:0]                      rx_shift;
      logic [31:0]                      tx_shift;
      logic [31:0]                      resp_word;
      logic                             miso;
      logic                             miso_oe;
      logic [1:0]                       keep_alive_counter;
      logic                             acq_run;
      logic                             snap_pending;
      logic [`SPI_RATE_BITS-1:0]        rate_count;
      logic [15:0][15:0]                live;
      logic [15:0][15:0]                snap;
   } slave_state_t;

endpackage

`default_nettype wire

// *** sample_fifo.sv ***
// small flip-flop FIFO between the sensing datapath and the sample bank
// assumes DEPTH is a power of two; one clock, synchronous active-low reset
`default_nettype none

module sample_fifo #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 8
) (
   input  wire logic             clock,
   input  wire logic             nrst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0]                 wr;
      logic [AW:0]                 rd;
   } fifo_state_t;

   fifo_state_t st;
   fifo_state_t next_st;
   logic        full;
   logic        empty;

   // extra pointer bit tells full from empty without a counter
   assign full      = (st.wr[AW] != st.rd[AW]) && (st.wr[AW-1:0] == st.rd[AW-1:0]);
   assign empty     = (st.wr == st.rd);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = st.mem[st.rd[AW-1:0]];

   always_comb
   begin
      next_st = st;
      if (in_valid && !full)
      begin
         next_st.mem[st.wr[AW-1:0]] = in_data;
         next_st.wr = (AW+1)'(st.wr + 1'b1);
      end
      if (out_ready && !empty)
      begin
         next_st.rd = (AW+1)'(st.rd + 1'b1);
      end
   end

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end
endmodule // sample_fifo

`default_nettype wire

// *** inertial_sensor_spi_slave.sv ***
// serial slave frame logic of a six-axis inertial sensor, with its sample bank
// assumes serial pins arrive asynchronously and are oversampled by the 20 MHz clock;
// samples and the alarm level come from logic on the same clock
//
// Operation
// - slave only; clock and select are inputs
// - select low span forms exactly one frame
// - data output released while select high
// - bits shifted most significant first
// - receiver captures on serial clock rise
// - transmitter changes bit on serial clock fall
// - a transaction is exactly 32 clocks
// - answer goes out in the next frame
// - response updated at select rising edge
// - samples refreshed 8000 times per second
// - data read: mode 101, select picks item
// - last four bits are CRC, init 0xa
// - error flag 10 normal, 01 on alarm
// - two-bit keep-alive counter per data read
`include "sensor_spi_regs.svh"
`default_nettype none

module inertial_sensor_spi_slave #(
   parameter int RATE_CYCLES = `SPI_CLOCK_HZ / `SPI_SAMPLE_HZ,
   parameter int FIFO_DEPTH  = `SPI_FIFO_DEPTH
) (
   input  wire logic                    clock,
   input  wire logic                    nrst,
   input  wire logic                    hardware_reset_n,
   input  wire logic                    chip_select_n,
   input  wire logic                    sclk,
   input  wire logic                    mosi,
   output logic                         miso,
   output logic                         miso_oe,
   input  wire logic                    alarm,
   input  wire logic                    sample_valid,
   output logic                         sample_ready,
   input  wire sensor_spi_pkg::sample_t sample_in
);
   localparam sensor_spi_pkg::slave_state_t RESET_STATE = '{
      cs_n_sync: 3'h7, hw_rst_sync: 2'h3, link: sensor_spi_pkg::LINK_IDLE, acq_run: 1'b1,
      resp_word: `SPI_RESET_RESP, default: '0};

   sensor_spi_pkg::slave_state_t st;
   sensor_spi_pkg::slave_state_t next_st;
   sensor_spi_pkg::sample_t      drain_data;
   logic                         drain_valid;
   logic                         drain_ready;
   logic                         cs_fall;
   logic                         cs_rise;
   logic                         sclk_rise;
   logic                         sclk_fall;
   logic                         rate_tick;
   logic                         frame_ok;
   logic                         hw_active;
   logic [3:0]                   select;
   logic [15:0]                  read_value;
   logic [27:0]                  resp_body;

   function automatic logic [3:0] crc4(input logic [27:0] d);
      logic [3:0] c;
      c = `SPI_CRC_INIT;
      // polynomial x^4+1: each bit folds into the lsb of a rotating nibble
      for (int i = 27; i >= 0; i--)
      begin
         c = {c[2:0], c[3] ^ d[i]};
      end
      return c;
   endfunction

   // samples wait here while acquisition is suspended; the source is stalled once all FIFO_DEPTH entries are full
   sample_fifo #(
      .WIDTH ($bits(sensor_spi_pkg::sample_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .nrst      (nrst),
      .in_valid  (sample_valid),
      .in_ready  (sample_ready),
      .in_data   (sample_in),
      .out_valid (drain_valid),
      .out_ready (drain_ready),
      .out_data  (drain_data)
   );

   // sync stage [0] feeds [1] only; [2] is the history for edge finding
   assign hw_active   = !st.hw_rst_sync[1];
   assign cs_fall     = st.cs_n_sync[2] && !st.cs_n_sync[1];
   assign cs_rise     = !st.cs_n_sync[2] && st.cs_n_sync[1];
   assign sclk_rise   = !st.sclk_sync[2] && st.sclk_sync[1];
   assign sclk_fall   = st.sclk_sync[2] && !st.sclk_sync[1];
   assign rate_tick   = (st.rate_count == `SPI_RATE_BITS'(RATE_CYCLES - 1));
   assign drain_ready = st.acq_run && !hw_active;
   assign select      = st.rx_shift[`SPI_SELECT_HI:`SPI_SELECT_LO];
   assign miso        = st.miso;
   assign miso_oe     = st.miso_oe;

   assign frame_ok = (st.bit_count == 6'(`SPI_FRAME_BITS)) &&
                     (st.rx_shift[`SPI_MODE_HI:`SPI_MODE_LO] == `SPI_MODE_DATA) &&
                     (crc4(st.rx_shift[`SPI_BODY_HI:`SPI_BODY_LO]) == st.rx_shift[`SPI_CRC_HI:`SPI_CRC_LO]);

   assign read_value = (select == `SPI_FIXED_SELECT) ? `SPI_FIXED_VALUE : st.snap[select];
   assign resp_body  = {read_value, alarm ? `SPI_FLAG_ALARM : `SPI_FLAG_OK,
                        `SPI_MODE_ECHO, select, st.rx_shift[`SPI_X2_POS], 1'b0, st.keep_alive_counter};

   always_comb
   begin
      next_st = st;
      // the 20 MHz clock oversamples a serial clock of at most 8 MHz
      next_st.cs_n_sync   = {st.cs_n_sync[1:0], chip_select_n};
      next_st.sclk_sync   = {st.sclk_sync[1:0], sclk};
      next_st.mosi_sync   = {st.mosi_sync[0], mosi};
      next_st.hw_rst_sync = {st.hw_rst_sync[0], hardware_reset_n};
      next_st.rate_count  = rate_tick ? '0 : `SPI_RATE_BITS'(st.rate_count + 1'b1);
      if (drain_valid && drain_ready)
      begin
         next_st.live[drain_data.index] = drain_data.value;
      end
      if (rate_tick && st.acq_run)
      begin
         next_st.snap = st.live;
      end
      case (st.link)
         sensor_spi_pkg::LINK_IDLE:
         begin
            // master keeps sclk low at select edges, so no bit is lost here
            if (cs_fall)
            begin
               next_st.link      = sensor_spi_pkg::LINK_FRAME;
               next_st.bit_count = '0;
               next_st.tx_shift  = st.resp_word;
               next_st.miso      = st.resp_word[`SPI_BIT_MSB];
               next_st.miso_oe   = 1'b1;
               if (st.snap_pending)
               begin
                  next_st.snap         = st.live;
                  next_st.snap_pending = 1'b0;
               end
            end
         end
         sensor_spi_pkg::LINK_FRAME:
         begin
            if (sclk_rise)
            begin
               next_st.rx_shift = {st.rx_shift[`SPI_BIT_NEXT:0], st.mosi_sync[1]};
               if (st.bit_count != 6'(`SPI_COUNT_LIMIT))
               begin
                  next_st.bit_count = 6'(st.bit_count + 1'b1);
               end
            end
            if (sclk_fall)
            begin
               next_st.tx_shift = {st.tx_shift[`SPI_BIT_NEXT:0], 1'b0};
               next_st.miso     = st.tx_shift[`SPI_BIT_NEXT];
            end
            if (cs_rise)
            begin
               next_st.link    = sensor_spi_pkg::LINK_IDLE;
               next_st.miso    = 1'b0;
               next_st.miso_oe = 1'b0;
               if (frame_ok)
               begin
                  next_st.resp_word          = {resp_body, crc4(resp_body)};
                  next_st.keep_alive_counter = 2'(st.keep_alive_counter + 1'b1);
                  next_st.acq_run            = st.rx_shift[`SPI_X2_POS];
                  next_st.snap_pending       = st.rx_shift[`SPI_X2_POS];
               end
            end
         end
         default:
         begin
            next_st = RESET_STATE;
         end
      endcase
      if (hw_active)
      begin
         next_st             = RESET_STATE;
         next_st.cs_n_sync   = {st.cs_n_sync[1:0], chip_select_n};
         next_st.sclk_sync   = {st.sclk_sync[1:0], sclk};
         next_st.mosi_sync   = {st.mosi_sync[0], mosi};
         next_st.hw_rst_sync = {st.hw_rst_sync[0], hardware_reset_n};
      end
   end

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         st <= RESET_STATE;
      end
      else
      begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst || hw_active);

   sequence s_frame_open;
      st.link == sensor_spi_pkg::LINK_IDLE && cs_fall;
   endsequence

   sequence s_good_close;
      st.link == sensor_spi_pkg::LINK_FRAME && cs_rise && frame_ok;
   endsequence

   sequence s_short_close;
      st.link == sensor_spi_pkg::LINK_FRAME && cs_rise && st.bit_count != 6'(`SPI_FRAME_BITS);
   endsequence

   a_idle_released: assert property (st.link == sensor_spi_pkg::LINK_IDLE |-> !st.miso_oe)
      else $error("data output driven outside a frame");
   a_first_bit_msb: assert property (s_frame_open |=> st.miso_oe && st.miso == $past(st.resp_word[`SPI_BIT_MSB]))
      else $error("first bit is not the response msb");
   a_rx_on_rise: assert property ($changed(st.rx_shift) |-> $past(sclk_rise))
      else $error("receive shift moved without a serial clock rise");
   a_tx_on_fall: assert property ($changed(st.miso) && st.miso_oe && $past(st.miso_oe) |-> $past(sclk_fall))
      else $error("output bit changed without a serial clock fall");
   a_tx_prior_resp: assert property (s_frame_open |=> st.tx_shift == $past(st.resp_word))
      else $error("frame did not load the prior response");
   a_resp_at_rise: assert property ($changed(st.resp_word) |-> $past(cs_rise))
      else $error("response changed away from a select rise");
   a_sample_refresh: assert property (rate_tick && st.acq_run |=> st.snap == $past(st.live))
      else $error("sample bank not refreshed at the rate tick");
   a_resp_crc_ok: assert property (st.resp_word[3:0] == crc4(st.resp_word[31:4]))
      else $error("response crc is wrong");
   a_error_flag: assert property (s_good_close |=>
      st.resp_word[15:14] == ($past(alarm) ? `SPI_FLAG_ALARM : `SPI_FLAG_OK))
      else $error("error flag does not follow alarm");
   a_keep_alive: assert property (s_good_close |=>
      st.keep_alive_counter == 2'($past(st.keep_alive_counter) + 2'h1))
      else $error("keep-alive counter did not step");
   a_count_restart: assert property (s_frame_open |=> st.bit_count == 6'h0)
      else $error("bit counter not restarted");
   a_short_dropped: assert property (s_short_close |=> $stable(st.resp_word) && $stable(st.keep_alive_counter))
      else $error("frame of wrong length was accepted");
   a_hwrst_idle: assert property (@(posedge clock) disable iff (!nrst)
      hw_active |=> st.link == sensor_spi_pkg::LINK_IDLE && !st.miso_oe && st.bit_count == 6'h0)
      else $error("hardware reset did not idle the link");
endmodule // inertial_sensor_spi_slave

`default_nettype wire

// *** spi_host_model.sv ***
// host side of the sensor serial link: drives select, serial clock and command data
// assumes the bench resolves the slave data line to z while its enable is low
`default_nettype none

module spi_host_model #(
   parameter int HALF_NS = 200
) (
   input  wire logic        miso_line,
   output logic             chip_select_n,
   output logic             sclk,
   output logic             mosi,
   output logic      [31:0] rx_word
);
   timeunit 1ns;
   timeprecision 100ps;

   event done;

   initial
   begin
      chip_select_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b1;
      rx_word = 32'h0;
   end

   // a clock count other than 32 makes a frame that the slave must drop
   task automatic frame(input logic [31:0] tx, input int nclk);
      logic [31:0] rx;
      rx = 32'h0;
      mosi = tx[31];
      chip_select_n = 1'b0;
      for (int i = 0; i < nclk; i++)
      begin
         #(HALF_NS);
         sclk = 1'b1;
         rx = {rx[30:0], miso_line};
         #(HALF_NS);
         sclk = 1'b0;
         if (i < 31)
            mosi = tx[30 - i];
      end
      #(HALF_NS);
      chip_select_n = 1'b1;
      // released line shows the inverse so a stale bit cannot pass for data
      mosi = ~mosi;
      if (nclk == 32)
      begin
         rx_word = rx;
         ->done;
      end
   endtask
endmodule // spi_host_model

`default_nettype wire

// *** tb_inertial_sensor_spi_slave.sv ***
// self-checking bench of the sensor serial slave with its sample buffer
// assumes the host model drives the link; samples and alarm come from this bench
`default_nettype none

module tb_inertial_sensor_spi_slave;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int RATE = 20;

   logic                    clock;
   logic                    nrst;
   logic                    hardware_reset_n;
   logic                    chip_select_n;
   logic                    sclk;
   logic                    mosi;
   logic                    miso;
   logic                    miso_oe;
   logic                    miso_line;
   logic                    alarm;
   logic                    sample_valid;
   logic                    sample_ready;
   sensor_spi_pkg::sample_t sample_in;
   logic [31:0]             rx_word;
   logic [31:0]             pending;
   logic [31:0]             expq[$];
   logic [15:0]             live[16];
   logic [15:0]             snap[16];
   logic [1:0]              keep_alive_counter;
   int                      error_cnt = 0;
   int                      n_compared = 0;
   int                      cycles = 0;

   assign miso_line = miso_oe ? miso : 1'bz;

   inertial_sensor_spi_slave #(.RATE_CYCLES(RATE), .FIFO_DEPTH(8)) i_dut (
      .clock(clock), .nrst(nrst), .hardware_reset_n(hardware_reset_n), .chip_select_n(chip_select_n),
      .sclk(sclk), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .alarm(alarm),
      .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_in(sample_in));

   spi_host_model i_host (
      .miso_line(miso_line), .chip_select_n(chip_select_n), .sclk(sclk), .mosi(mosi), .rx_word(rx_word));

   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   function automatic logic [31:0] with_crc(input logic [27:0] b);
      logic [3:0] c;
      c = 4'ha;
      for (int i = 0; i < 7; i++)
         c ^= b[4*i +: 4];
      return {b, c};
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize;
      if (error_cnt == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // bad: 0 good, 1 short frame, 2 broken check bits, 3 wrong mode
   task automatic cmd(input logic [3:0] sel, input logic x2, input int bad);
      logic [31:0] w;
      logic [15:0] d;
      w = with_crc({16'h0, 3'b101, 1'b0, sel, x2, 3'h0});
      if (bad == 2)
         w[0] = ~w[0];
      if (bad == 3)
         w = with_crc({16'h0, 3'b100, 1'b0, sel, x2, 3'h0});
      @(negedge clock);
      alarm = 1'($urandom);
      if (bad != 1)
         expq.push_back(pending);
      i_host.frame(w, (bad == 1) ? 31 : 32);
      d = (sel == 4'hf) ? 16'haa55 : snap[sel];
      if (bad == 0)
      begin
         pending = with_crc({d, alarm ? 2'b01 : 2'b10, 2'b10, sel, x2, 1'b0, keep_alive_counter});
         keep_alive_counter++;
      end
      repeat (5) @(negedge clock);
      check("released data line", {31'h0, miso_line}, {31'h0, 1'bz});
   endtask

   // leaves valid high so back-to-back calls never toggle it within one step
   task automatic put_sample(input logic [3:0] idx, input logic [15:0] v);
      sample_valid = 1'b1;
      sample_in = '{index: idx, value: v};
      while (sample_ready !== 1'b1)
         @(negedge clock);
      @(negedge clock);
      live[idx] = v;
   endtask

   initial
   begin
      forever
      begin
         @(i_host.done);
         if (expq.size() == 0)
            check("unexpected frame", 32'h1, 32'h0);
         else
            check("response word", rx_word, expq.pop_front());
      end
   end

   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         error_cnt++;
         summarize();
      end
   end

   initial
   begin
      void'($urandom(32'hf09a));
      nrst = 1'b0;
      hardware_reset_n = 1'b1;
      alarm = 1'b0;
      sample_valid = 1'b0;
      sample_in = '0;
      pending = with_crc(28'h0);
      keep_alive_counter = 2'h0;
      foreach (live[i])
         live[i] = 16'h0;
      snap = live;
      repeat (6) @(negedge clock);
      nrst = 1'b1;
      repeat (4) @(negedge clock);
      for (int i = 0; i < 15; i++)
         put_sample(4'(i), 16'($urandom));
      sample_valid = 1'b0;
      repeat (3 * RATE) @(negedge clock);
      snap = live;
      for (int i = 0; i < 20; i++)
         cmd(4'(i), 1'b1, 0);
      for (int b = 1; b < 4; b++)
         cmd(4'h3, 1'b1, b);
      // suspended acquisition stops draining, so the buffer must fill and refuse
      cmd(4'h0, 1'b0, 0);
      for (int i = 0; i < 8; i++)
         put_sample(4'h1, 16'($urandom));
      sample_valid = 1'b0;
      check("buffer full", {31'h0, sample_ready}, 32'h0);
      cmd(4'h1, 1'b0, 0);
      cmd(4'h1, 1'b1, 0);
      repeat (10) @(negedge clock);
      check("buffer drained", {31'h0, sample_ready}, 32'h1);
      snap = live;
      cmd(4'h1, 1'b1, 0);
      // one more frame carries the freshly drained sample back to the host
      cmd(4'h1, 1'b1, 0);
      // pulse kept short: the logic needs one clock of low level, the full minimum would overrun the run budget
      hardware_reset_n = 1'b0;
      repeat (10) @(negedge clock);
      check("data enable in reset", {31'h0, miso_oe}, 32'h0);
      hardware_reset_n = 1'b1;
      repeat (6) @(negedge clock);
      pending = with_crc(28'h0);
      keep_alive_counter = 2'h0;
      cmd(4'hf, 1'b1, 0);
      cmd(4'hf, 1'b1, 0);
      cmd(4'hf, 1'b1, 0);
      check("notes left over", 32'(expq.size()), 32'h0);
      summarize();
   end
endmodule // tb_inertial_sensor_spi_slave

`default_nettype wire
